/* rtl/dse_defines.vh */
// constants for the decrement-skip and flash erase execution block
`ifndef DSE_DEFINES_VH
`define DSE_DEFINES_VH
`define DSE_OP_DSNZ_MEM 7'h27
`define DSE_OP_DSNZ_ACC 7'h26
`define DSE_OP_DSZ_MEM 7'h17
`define DSE_OP_DSZ_ACC 7'h16
`define DSE_OP_ERASE 16'h0003
`define DSE_OP_HI 15
`define DSE_OP_LO 9
`define DSE_FR_HI 8
`define DSE_FR_LO 0
`define DSE_ERASE_ID 3'h5
`define DSE_BUSY_RST 1'b0
`define DSE_FLASH_BASE_HI 8'h00
`define DSE_FLASH_LAST_HI 8'hff
`endif

/* rtl/dse_file_mem.v */
// small data memory standing in for the file registers
`timescale 1ns/1ns
`default_nettype none
module dse_file_mem (
  // clock
  input wire i_clk,
  // port
  input wire [8:0] i_raddr,
  input wire i_we,
  input wire [8:0] i_waddr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata
);
  reg [7:0] mem_reg [0:511];
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_raddr];
  end
endmodule // dse_file_mem
`default_nettype wire

/* rtl/dse_erase_track.v */
// busy flag and erase launch for the program flash
`timescale 1ns/1ns
`default_nettype none
`include "dse_defines.vh"
module dse_erase_track (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // requests
  input wire i_erase,
  input wire [7:0] i_addr_hi,
  input wire i_other_op,
  input wire i_flash_done,
  // results
  output reg o_erase_start,
  output reg [7:0] o_erase_block,
  output reg o_busy
);
  wire in_flash;
  assign in_flash = (i_addr_hi >= `DSE_FLASH_BASE_HI) &&
    (i_addr_hi <= `DSE_FLASH_LAST_HI);
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_erase_start <= 1'b0;
      o_erase_block <= 8'h00;
      o_busy <= `DSE_BUSY_RST;
    end else begin
      o_erase_start <= i_erase && in_flash;
      if (i_erase && in_flash) begin
        o_erase_block <= i_addr_hi;
      end
      // a new launch wins over a completion in the same cycle
      if ((i_erase && in_flash) || i_other_op) begin
        o_busy <= 1'b1;
      end else if (i_flash_done) begin
        o_busy <= 1'b0;
      end
    end
  end
endmodule // dse_erase_track
`default_nettype wire

/* rtl/dse_exec.v */
// execution of decrement-and-skip forms and the flash block erase
`timescale 1ns/1ns
`default_nettype none
`include "dse_defines.vh"
module dse_exec (
  // clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // instruction issue
  input wire i_valid,
  input wire [15:0] i_instr,
  input wire i_fetch_from_flash,
  // flash side
  input wire [7:0] i_addr_hi,
  input wire i_other_flash_op,
  input wire i_flash_done,
  // data memory preload port
  input wire i_mem_we,
  input wire [8:0] i_mem_addr,
  input wire [7:0] i_mem_wdata,
  // results
  output reg [7:0] o_acc,
  output reg o_acc_we,
  output reg o_mem_we,
  output reg [8:0] o_mem_addr,
  output reg [7:0] o_mem_wdata,
  output reg o_annul,
  output reg o_retire,
  output reg o_stall,
  output reg o_status_we,
  output reg o_fetch_block,
  output wire o_erase_start,
  output wire [7:0] o_erase_block,
  output wire o_busy
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg state_reg;
  reg [6:0] op_reg;
  reg [8:0] fr_reg;
  reg annul_reg;
  wire [6:0] op;
  wire is_dec;
  wire is_erase;
  wire [7:0] rdata;
  wire [7:0] dec_val;
  wire is_zero;
  wire skip;
  wire wb_mem;

  assign op = i_instr[`DSE_OP_HI:`DSE_OP_LO];
  assign is_dec = i_valid && !annul_reg && (op == `DSE_OP_DSNZ_MEM ||
    op == `DSE_OP_DSNZ_ACC || op == `DSE_OP_DSZ_MEM ||
    op == `DSE_OP_DSZ_ACC);
  // an annulled slot never reaches the erase launcher
  assign is_erase = i_valid && !annul_reg &&
    (i_instr == `DSE_OP_ERASE);
  assign dec_val = rdata - 8'h01;
  assign is_zero = (dec_val == 8'h00);
  assign skip = (op_reg == `DSE_OP_DSNZ_MEM ||
    op_reg == `DSE_OP_DSNZ_ACC) ? !is_zero : is_zero;
  assign wb_mem = (op_reg == `DSE_OP_DSNZ_MEM) ||
    (op_reg == `DSE_OP_DSZ_MEM);

  // operand is read one cycle after issue, so the op holds one stall cycle
  dse_file_mem u_mem (
    .i_clk(i_clk),
    .i_raddr(i_instr[`DSE_FR_HI:`DSE_FR_LO]),
    .i_we(i_mem_we || (state_reg == ST_EXEC && wb_mem)),
    .i_waddr(state_reg == ST_EXEC ? fr_reg : i_mem_addr),
    .i_wdata(state_reg == ST_EXEC ? dec_val : i_mem_wdata),
    .o_rdata(rdata)
  );

  dse_erase_track u_track (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_erase(is_erase),
    .i_addr_hi(i_addr_hi),
    .i_other_op(i_other_flash_op),
    .i_flash_done(i_flash_done),
    .o_erase_start(o_erase_start),
    .o_erase_block(o_erase_block),
    .o_busy(o_busy)
  );

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      op_reg <= 7'h00;
      fr_reg <= 9'h000;
      annul_reg <= 1'b0;
      o_acc <= 8'h00;
      o_acc_we <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 9'h000;
      o_mem_wdata <= 8'h00;
      o_annul <= 1'b0;
      o_retire <= 1'b0;
      o_stall <= 1'b0;
      o_status_we <= 1'b0;
      o_fetch_block <= 1'b0;
    end else begin
      o_acc_we <= 1'b0;
      o_mem_we <= 1'b0;
      o_retire <= 1'b0;
      o_annul <= 1'b0;
      o_status_we <= 1'b0;
      o_fetch_block <= o_busy && i_fetch_from_flash;
      case (state_reg)
        ST_IDLE: begin
          o_stall <= 1'b0;
          if (annul_reg && i_valid) begin
            annul_reg <= 1'b0;
            o_annul <= 1'b1;
          end else if (is_dec) begin
            op_reg <= op;
            fr_reg <= i_instr[`DSE_FR_HI:`DSE_FR_LO];
            o_stall <= 1'b1;
            state_reg <= ST_EXEC;
          end else if (is_erase) begin
            o_retire <= 1'b1;
          end
        end
        ST_EXEC: begin
          o_stall <= 1'b0;
          o_retire <= 1'b1;
          annul_reg <= skip;
          if (wb_mem) begin
            o_mem_we <= 1'b1;
            o_mem_addr <= fr_reg;
            o_mem_wdata <= dec_val;
          end else begin
            o_acc_we <= 1'b1;
            o_acc <= dec_val;
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // dse_exec
`default_nettype wire

/* testbench/dse_flash_model.sv */
// flash array stand-in that ends each operation after a set delay
`timescale 1ns/1ns
`default_nettype none
module dse_flash_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [3:0] i_lat,
  output logic o_done
);
  int cnt;
  // one operation at a time: software never starts one while busy
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 1);
      cnt <= i_start ? int'(i_lat) : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule // dse_flash_model
`default_nettype wire

/* testbench/dse_exec_sva.sv */
// assertions on the ports of the execution block
`timescale 1ns/1ns
`default_nettype none
module dse_exec_sva (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_other_flash_op,
  input wire logic i_flash_done,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_addr_hi,
  input wire logic o_stall,
  input wire logic o_retire,
  input wire logic o_acc_we,
  input wire logic o_mem_we,
  input wire logic o_status_we,
  input wire logic o_erase_start,
  input wire logic o_busy,
  input wire logic [8:0] o_mem_addr,
  input wire logic [7:0] o_erase_block
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_ret; o_stall |=> o_retire && !o_stall; endproperty
  a_ret: assert property (p_ret) else $error("no retire");
  property p_flag; !o_status_we; endproperty
  a_flag: assert property (p_flag) else $error("status written");
  property p_dest; o_acc_we |-> !o_mem_we && o_retire; endproperty
  a_dest: assert property (p_dest) else $error("both written");
  property p_addr; o_mem_we |-> o_mem_addr == $past(i_instr[8:0], 2); endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_blk; o_erase_start |-> o_erase_block == $past(i_addr_hi); endproperty
  a_blk: assert property (p_blk) else $error("bad block");
  property p_start; o_erase_start |-> o_busy && o_retire; endproperty
  a_start: assert property (p_start) else $error("no busy");
  property p_fell; $fell(o_busy) |-> $past(i_flash_done); endproperty
  a_fell: assert property (p_fell) else $error("busy dropped");
  property p_rose; $rose(o_busy) |-> o_erase_start || $past(i_other_flash_op);
  endproperty
  a_rose: assert property (p_rose) else $error("busy raised");
  c_dec: cover property (o_stall ##1 o_mem_we);
  c_acc: cover property (o_stall ##1 o_acc_we);
  c_erase: cover property (o_erase_start ##[1:20] !o_busy);
endmodule // dse_exec_sva
bind dse_exec dse_exec_sva chk_u (.*);
`default_nettype wire

/* testbench/test_dse_exec.sv */
// testbench for the decrement-skip and flash erase block
`timescale 1ns/1ns
`default_nettype none
`include "dse_defines.vh"
module test_dse_exec;
  logic i_clk = 0, i_rst_b = 0, i_valid = 0, i_fetch_from_flash = 0;
  logic i_other_flash_op = 0, i_mem_we = 0, i_flash_done;
  logic [15:0] i_instr = 0;
  logic [8:0] i_mem_addr = 0, o_mem_addr;
  logic [7:0] i_mem_wdata = 0, i_addr_hi = 0, o_acc, o_mem_wdata, o_erase_block;
  logic o_acc_we, o_mem_we, o_annul, o_retire, o_stall, o_status_we;
  logic o_fetch_block, o_erase_start, o_busy;
  logic [3:0] lat = 4'h3;
  logic [6:0] ops [4] = '{`DSE_OP_DSNZ_MEM, `DSE_OP_DSNZ_ACC,
    `DSE_OP_DSZ_MEM, `DSE_OP_DSZ_ACC};
  logic [7:0] vals [3] = '{8'h01, 8'h00, 8'h75};
  int num_errors = 0, checked = 0;
  always #20 i_clk = ~i_clk;
  dse_exec dut_u (.*);
  dse_flash_model fm_u (.i_clk, .i_rst_b, .i_lat(lat),
    .i_start(o_erase_start | i_other_flash_op), .o_done(i_flash_done));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic idle();
    repeat (20) if (o_busy) tick();
    chk(o_busy, 1'b0);
  endtask
  task automatic dec(input logic [6:0] op, input logic [7:0] v, input bit ld);
    logic [7:0] r;
    r = v - 8'h01;
    i_mem_we = ld;
    i_mem_addr = 9'h1a5;
    i_mem_wdata = v;
    tick();
    i_mem_we = 0;
    i_instr = {op, 9'h1a5};
    i_valid = 1;
    tick();
    i_valid = 0;
    chk(o_stall, 1'b1);
    tick();
    // memory forms write back, accumulator forms write only the result
    chk({o_retire, o_mem_we, o_acc_we, o_status_we},
      {1'b1, op[0], !op[0], 1'b0});
    chk(op[0] ? o_mem_wdata : o_acc, r);
    i_instr = 16'h0000;
    i_valid = 1;
    tick();
    i_valid = 0;
    chk(o_annul, op[5] ? r != 8'h00 : r == 8'h00);
    $display("dec %h value %h done", op, v);
  endtask
  task automatic erase(input logic [7:0] hi);
    i_addr_hi = hi;
    i_instr = `DSE_OP_ERASE;
    i_valid = 1;
    tick();
    i_valid = 0;
    i_fetch_from_flash = 1;
    chk({o_erase_start, o_retire, o_busy, o_stall}, 4'he);
    chk(o_erase_block, hi);
    tick();
    chk(o_fetch_block, 1'b1);
    i_fetch_from_flash = 0;
    idle();
    $display("erase %h done", hi);
  endtask
  task automatic final_report();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_rst_b = 1;
    foreach (ops[i]) foreach (vals[j]) dec(ops[i], vals[j], 1'b1);
    dec(`DSE_OP_DSZ_ACC, 8'h42, 1'b1);
    dec(`DSE_OP_DSNZ_MEM, 8'h42, 1'b0);
    erase(8'h83);
    lat = 4'hc;
    erase(8'h00);
    i_other_flash_op = 1;
    tick();
    i_other_flash_op = 0;
    chk(o_busy, 1'b1);
    idle();
    final_report();
  end
endmodule // test_dse_exec
`default_nettype wire
